// [include/dtei_map.vh]
// Register indices, field positions, reset values and tick divisors for the dual timer
`ifndef DTEI_MAP_VH
`define DTEI_MAP_VH

// Register indices; the byte address is four times the index
`define DTEI_IDX_CTRL      8'h88
`define DTEI_IDX_MODE      8'h89
`define DTEI_IDX_A_LOW     8'h8a
`define DTEI_IDX_B_LOW     8'h8b
`define DTEI_IDX_A_HIGH    8'h8c
`define DTEI_IDX_B_HIGH    8'h8d
`define DTEI_IDX_TICK_SEL  8'h8e
`define DTEI_IDX_IRQ_STAT  8'h90
`define DTEI_IDX_IRQ_MASK  8'h91

// Control/flag register fields
`define DTEI_CTRL_TF_B     7
`define DTEI_CTRL_RUN_B    6
`define DTEI_CTRL_TF_A     5
`define DTEI_CTRL_RUN_A    4
`define DTEI_CTRL_IE_B     3
`define DTEI_CTRL_IT_B     2
`define DTEI_CTRL_IE_A     1
`define DTEI_CTRL_IT_A     0

// Mode register fields
`define DTEI_MODE_GATE_B   7
`define DTEI_MODE_CT_B     6
`define DTEI_MODE_B_HI     5
`define DTEI_MODE_B_LO     4
`define DTEI_MODE_GATE_A   3
`define DTEI_MODE_CT_A     2
`define DTEI_MODE_A_HI     1
`define DTEI_MODE_A_LO     0

// Tick select fields
`define DTEI_TSEL_B        4
`define DTEI_TSEL_A        3

// Interrupt status/mask fields
`define DTEI_IRQ_TF_A      0
`define DTEI_IRQ_TF_B      1
`define DTEI_IRQ_EXT_A     2
`define DTEI_IRQ_EXT_B     3

// Reset values
`define DTEI_RST_BYTE      8'h00
`define DTEI_RST_NIBBLE    4'h0

// Timer modes
`define DTEI_M_13BIT       2'h0
`define DTEI_M_16BIT       2'h1
`define DTEI_M_RELOAD      2'h2
`define DTEI_M_SPLIT       2'h3

// Internal tick divisors in system clocks
`define DTEI_DIV_SLOW      12
`define DTEI_DIV_FAST      4
`define DTEI_PRE_LAST      4'hb

`endif

// [verilog/dtei_pin_sync.v]
// Two-flop pin synchroniser with a falling-edge detector on the settled level
`timescale 1ns/1ns
`default_nettype none
module dtei_pin_sync (
	// Clock and reset
	input  wire clock,
	input  wire sys_rst,
	// Pin and results
	input  wire pin,
	output wire level,
	output wire fall
);
	reg meta_reg;
	reg sync_reg;
	reg prev_reg;

	// Pins idle high, so the flops reset to one to avoid a false edge
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			prev_reg <= 1'b1;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// Only the settled stages feed the edge detector
	assign level = sync_reg;
	assign fall  = prev_reg & ~sync_reg;
endmodule
`default_nettype wire

// [verilog/dtei_top.v]
// Dual 16-bit timer/counter with external interrupt detectors behind an AHB-Lite slave
// Function
// (R01) Overflow sets timer flag; software may clear
// (R02) Vector acknowledge clears timer overflow flag
// (R03) Run bit halts or enables, count kept
// (R04) Edge mode request sticky until cleared/acknowledged
// (R05) Level mode request reads inverse of pin
// (R06) Type bit: zero level, one edge
// (R07) Gate set: count only with pin high
// (R08) Select internal tick or count pin pulses
// (R09) Modes: 13-bit prescaled, 16-bit, auto-reload
// (R10) Second timer mode 3 holds its count
// (R11) First timer mode 3: two 8-bit counters
// (R12) Second timer run follows its mode then
// (R13) Low count bytes readable, writable, reset zero
// (R14) High count bytes readable, writable, reset zero
// (R15) Tick select: divide by 12 or 4
// (R16) 13-bit mode layout; reload low from high
// (R17) Pins synchronised; count on falling edge
// (R18) First timer high byte overflow sets second flag
`timescale 1ns/1ns
`default_nettype none
`include "dtei_map.vh"
module dtei_top (
	// Clock and reset
	input  wire        clock,
	input  wire        sys_rst,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// External pins
	input  wire        timer_a_count_pin,
	input  wire        timer_b_count_pin,
	input  wire        ext_irq_a_pin,
	input  wire        ext_irq_b_pin,
	// Interrupt controller side
	input  wire        ack_timer_a,
	input  wire        ack_timer_b,
	input  wire        ack_ext_a,
	input  wire        ack_ext_b,
	output reg  [3:0]  request_flags,
	output reg         irq
);
	// Register state
	reg [7:0] ctrl_reg;
	reg [7:0] ctrl_next;
	reg [7:0] mode_reg;
	reg [7:0] tl_a_reg;
	reg [7:0] tl_a_next;
	reg [7:0] th_a_reg;
	reg [7:0] th_a_next;
	reg [7:0] tl_b_reg;
	reg [7:0] tl_b_next;
	reg [7:0] th_b_reg;
	reg [7:0] th_b_next;
	reg [1:0] tsel_reg;
	reg [3:0] stat_reg;
	reg [3:0] stat_next;
	reg [3:0] mask_reg;
	reg [3:0] pre_reg;
	reg       wr_pend_reg;
	reg [7:0] wr_idx_reg;
	reg       ovf_a;
	reg       ovf_ah;
	reg       ovf_b;
	reg [7:0] rd_byte;
	reg [3:0] req_now;

	// Synchronised pins; count pins only need their falling edge
	wire cnt_a_fall;
	wire cnt_b_fall;
	wire irq_a_lvl;
	wire irq_a_fall;
	wire irq_b_lvl;
	wire irq_b_fall;

	// Four identical synchronisers, one per pin
	dtei_pin_sync u_sync_cnt_a (
		.clock   (clock),
		.sys_rst (sys_rst),
		.pin     (timer_a_count_pin),
		.level   (),
		.fall    (cnt_a_fall)
	);
	dtei_pin_sync u_sync_cnt_b (
		.clock   (clock),
		.sys_rst (sys_rst),
		.pin     (timer_b_count_pin),
		.level   (),
		.fall    (cnt_b_fall)
	);
	dtei_pin_sync u_sync_irq_a (
		.clock   (clock),
		.sys_rst (sys_rst),
		.pin     (ext_irq_a_pin),
		.level   (irq_a_lvl),
		.fall    (irq_a_fall)
	);
	dtei_pin_sync u_sync_irq_b (
		.clock   (clock),
		.sys_rst (sys_rst),
		.pin     (ext_irq_b_pin),
		.level   (irq_b_lvl),
		.fall    (irq_b_fall)
	);

	// One step of a timer in modes 0 to 2: returns {overflow, high, low}
	function [16:0] dtei_step;
		input [1:0] m;
		input [7:0] th;
		input [7:0] tl;
		reg   [12:0] c13;
		reg   [15:0] c16;
		begin
			c13 = {th, tl[4:0]} + 13'h0001;
			c16 = {th, tl} + 16'h0001;
			case (m)
				`DTEI_M_13BIT: begin
					dtei_step = {({th, tl[4:0]} == 13'h1fff), c13[12:5], tl[7:5], c13[4:0]}; // R16
				end
				`DTEI_M_16BIT: begin
					dtei_step = {({th, tl} == 16'hffff), c16};
				end
				`DTEI_M_RELOAD: begin
					if (tl == 8'hff) begin
						dtei_step = {1'b1, th, th}; // R16
					end else begin
						dtei_step = {1'b0, th, tl + 8'h01};
					end
				end
				default: begin
					dtei_step = {1'b0, th, tl};
				end
			endcase
		end
	endfunction

	// Field decode
	wire [1:0] mode_a = mode_reg[`DTEI_MODE_A_HI:`DTEI_MODE_A_LO];
	wire [1:0] mode_b = mode_reg[`DTEI_MODE_B_HI:`DTEI_MODE_B_LO];
	wire       a_split = (mode_a == `DTEI_M_SPLIT);
	wire       run_a = ctrl_reg[`DTEI_CTRL_RUN_A];
	wire       run_b = ctrl_reg[`DTEI_CTRL_RUN_B];
	wire       type_a = ctrl_reg[`DTEI_CTRL_IT_A];
	wire       type_b = ctrl_reg[`DTEI_CTRL_IT_B];

	// Shared prescaler: every 4th and every 12th clock from one counter
	wire tick_slow = (pre_reg == `DTEI_PRE_LAST);
	wire tick_fast = (pre_reg[1:0] == 2'h3);
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pre_reg <= `DTEI_RST_NIBBLE;
		end else if (tick_slow) begin
			pre_reg <= `DTEI_RST_NIBBLE;
		end else begin
			pre_reg <= pre_reg + 4'h1;
		end
	end
	wire tick_a = tsel_reg[0] ? tick_fast : tick_slow; // R15
	wire tick_b = tsel_reg[1] ? tick_fast : tick_slow; // R15

	// Count enables: run, gate and source select
	wire gate_ok_a = ~mode_reg[`DTEI_MODE_GATE_A] | irq_a_lvl; // R07
	wire gate_ok_b = ~mode_reg[`DTEI_MODE_GATE_B] | irq_b_lvl; // R07
	wire src_a = mode_reg[`DTEI_MODE_CT_A] ? cnt_a_fall : tick_a; // R08 R17
	wire src_b = mode_reg[`DTEI_MODE_CT_B] ? cnt_b_fall : tick_b; // R08 R17
	wire inc_a = run_a & gate_ok_a & src_a; // R03
	// With the first timer split, the second loses its run bit and runs unless in mode 3
	wire run_b_eff = a_split | run_b; // R12
	wire inc_b = (mode_b != `DTEI_M_SPLIT) & run_b_eff & gate_ok_b & src_b; // R10 R03
	// Split high byte is a plain timer on the internal tick, run by the second run bit
	wire inc_ah = a_split & run_b & tick_a; // R11

	// Bus write strobes, taken in the data phase
	wire wr_ctrl = wr_pend_reg & (wr_idx_reg == `DTEI_IDX_CTRL);
	wire wr_mode = wr_pend_reg & (wr_idx_reg == `DTEI_IDX_MODE);
	wire wr_tla  = wr_pend_reg & (wr_idx_reg == `DTEI_IDX_A_LOW);
	wire wr_tlb  = wr_pend_reg & (wr_idx_reg == `DTEI_IDX_B_LOW);
	wire wr_tha  = wr_pend_reg & (wr_idx_reg == `DTEI_IDX_A_HIGH);
	wire wr_thb  = wr_pend_reg & (wr_idx_reg == `DTEI_IDX_B_HIGH);
	wire wr_tsel = wr_pend_reg & (wr_idx_reg == `DTEI_IDX_TICK_SEL);
	wire wr_stat = wr_pend_reg & (wr_idx_reg == `DTEI_IDX_IRQ_STAT);
	wire wr_mask = wr_pend_reg & (wr_idx_reg == `DTEI_IDX_IRQ_MASK);
	wire [7:0] wbyte = hwdata[7:0];

	wire [16:0] step_a = dtei_step(mode_a, th_a_reg, tl_a_reg);
	wire [16:0] step_b = dtei_step(mode_b, th_b_reg, tl_b_reg);

	// Counter next state; a bus write to a byte wins over counting in that cycle
	always @* begin
		tl_a_next = tl_a_reg;
		th_a_next = th_a_reg;
		tl_b_next = tl_b_reg;
		th_b_next = th_b_reg;
		ovf_a = 1'b0;
		ovf_ah = 1'b0;
		ovf_b = 1'b0;
		if (a_split) begin
			if (inc_a) begin
				tl_a_next = tl_a_reg + 8'h01; // R11
				ovf_a = (tl_a_reg == 8'hff);
			end
			if (inc_ah) begin
				th_a_next = th_a_reg + 8'h01; // R11
				ovf_ah = (th_a_reg == 8'hff);
			end
		end else if (inc_a) begin
			{ovf_a, th_a_next, tl_a_next} = step_a; // R09
		end
		if (inc_b) begin
			{ovf_b, th_b_next, tl_b_next} = step_b; // R09
		end
		if (wr_tla) begin
			tl_a_next = wbyte; // R13
		end
		if (wr_tlb) begin
			tl_b_next = wbyte; // R13
		end
		if (wr_tha) begin
			th_a_next = wbyte; // R14
		end
		if (wr_thb) begin
			th_b_next = wbyte; // R14
		end
	end

	// Flag sources
	wire set_tf_a = ovf_a; // R01
	// While split, the second flag belongs to the first timer's high byte
	wire set_tf_b = a_split ? ovf_ah : ovf_b; // R18 R01
	wire set_ie_a = type_a & irq_a_fall; // R04
	wire set_ie_b = type_b & irq_b_fall; // R04

	// Control register next: hardware set wins over a software or acknowledge clear
	always @* begin
		ctrl_next = wr_ctrl ? wbyte : ctrl_reg;
		if (!wr_ctrl) begin
			ctrl_next[`DTEI_CTRL_TF_A] = ctrl_reg[`DTEI_CTRL_TF_A] & ~ack_timer_a; // R02
			ctrl_next[`DTEI_CTRL_TF_B] = ctrl_reg[`DTEI_CTRL_TF_B] & ~ack_timer_b; // R02
			ctrl_next[`DTEI_CTRL_IE_A] = ctrl_reg[`DTEI_CTRL_IE_A] & ~ack_ext_a; // R04
			ctrl_next[`DTEI_CTRL_IE_B] = ctrl_reg[`DTEI_CTRL_IE_B] & ~ack_ext_b; // R04
		end
		ctrl_next[`DTEI_CTRL_TF_A] = ctrl_next[`DTEI_CTRL_TF_A] | set_tf_a; // R01
		ctrl_next[`DTEI_CTRL_TF_B] = ctrl_next[`DTEI_CTRL_TF_B] | set_tf_b; // R01
		// Edge latches are held clear in level mode so a switch to edge starts clean
		ctrl_next[`DTEI_CTRL_IE_A] = ctrl_next[`DTEI_CTRL_IT_A] & (ctrl_next[`DTEI_CTRL_IE_A] | set_ie_a); // R06
		ctrl_next[`DTEI_CTRL_IE_B] = ctrl_next[`DTEI_CTRL_IT_B] & (ctrl_next[`DTEI_CTRL_IE_B] | set_ie_b); // R06
	end

	// Visible request bits: timer overflow flags, then for each pin its edge latch or inverted pin level
	always @* begin
		req_now[0] = ctrl_next[`DTEI_CTRL_TF_A];
		req_now[1] = ctrl_next[`DTEI_CTRL_TF_B];
		req_now[2] = ctrl_next[`DTEI_CTRL_IT_A] ? ctrl_next[`DTEI_CTRL_IE_A] : ~irq_a_lvl; // R05
		req_now[3] = ctrl_next[`DTEI_CTRL_IT_B] ? ctrl_next[`DTEI_CTRL_IE_B] : ~irq_b_lvl; // R05
	end

	// Sticky event status, write one to clear; a new event beats the clear
	always @* begin
		stat_next = wr_stat ? (stat_reg & ~wbyte[3:0]) : stat_reg;
		stat_next[`DTEI_IRQ_TF_A] = stat_next[`DTEI_IRQ_TF_A] | set_tf_a;
		stat_next[`DTEI_IRQ_TF_B] = stat_next[`DTEI_IRQ_TF_B] | set_tf_b;
		stat_next[`DTEI_IRQ_EXT_A] = stat_next[`DTEI_IRQ_EXT_A] | irq_a_fall;
		stat_next[`DTEI_IRQ_EXT_B] = stat_next[`DTEI_IRQ_EXT_B] | irq_b_fall;
	end

	// Read multiplexer, sampled in the address phase
	always @* begin
		case (haddr[9:2])
			`DTEI_IDX_CTRL: begin
				rd_byte = {ctrl_reg[7:4], req_now[3], ctrl_reg[2], req_now[2], ctrl_reg[0]};
			end
			`DTEI_IDX_MODE: begin
				rd_byte = mode_reg;
			end
			`DTEI_IDX_A_LOW: begin
				rd_byte = tl_a_reg; // R13
			end
			`DTEI_IDX_B_LOW: begin
				rd_byte = tl_b_reg; // R13
			end
			`DTEI_IDX_A_HIGH: begin
				rd_byte = th_a_reg; // R14
			end
			`DTEI_IDX_B_HIGH: begin
				rd_byte = th_b_reg; // R14
			end
			`DTEI_IDX_TICK_SEL: begin
				rd_byte = {3'h0, tsel_reg[1], tsel_reg[0], 3'h0};
			end
			`DTEI_IDX_IRQ_STAT: begin
				rd_byte = {4'h0, stat_reg};
			end
			`DTEI_IDX_IRQ_MASK: begin
				rd_byte = {4'h0, mask_reg};
			end
			default: begin
				rd_byte = `DTEI_RST_BYTE;
			end
		endcase
		if (haddr[31:10] != 22'h000000) begin
			rd_byte = `DTEI_RST_BYTE;
		end
	end

	// Address phase accepted when selected, active and the bus is ready
	wire addr_ok = hsel & htrans[1] & hready;

	// Bus slave: zero wait states, always OKAY
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= `DTEI_RST_BYTE;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready) begin
				wr_pend_reg <= addr_ok & hwrite & (haddr[31:10] == 22'h000000);
				wr_idx_reg <= haddr[9:2];
			end
			if (addr_ok & ~hwrite) begin
				hrdata <= {24'h000000, rd_byte};
			end
		end
	end

	// Register update
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg <= `DTEI_RST_BYTE;
			mode_reg <= `DTEI_RST_BYTE;
			tl_a_reg <= `DTEI_RST_BYTE; // R13
			tl_b_reg <= `DTEI_RST_BYTE; // R13
			th_a_reg <= `DTEI_RST_BYTE; // R14
			th_b_reg <= `DTEI_RST_BYTE; // R14
			tsel_reg <= 2'h0;
			stat_reg <= `DTEI_RST_NIBBLE;
			mask_reg <= `DTEI_RST_NIBBLE;
			request_flags <= `DTEI_RST_NIBBLE;
			irq <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			tl_a_reg <= tl_a_next;
			tl_b_reg <= tl_b_next;
			th_a_reg <= th_a_next;
			th_b_reg <= th_b_next;
			stat_reg <= stat_next;
			if (wr_mode) begin
				mode_reg <= wbyte;
			end
			if (wr_tsel) begin
				tsel_reg <= {wbyte[`DTEI_TSEL_B], wbyte[`DTEI_TSEL_A]};
			end
			if (wr_mask) begin
				mask_reg <= wbyte[3:0];
			end
			// Outputs follow the next state so they line up with the registers
			request_flags <= req_now;
			irq <= |(stat_next & (wr_mask ? wbyte[3:0] : mask_reg));
		end
	end
endmodule
`default_nettype wire

// [tb/dtei_properties.sv]
// Concurrent checks on the dual timer's bus, request flag and interrupt ports
`timescale 1ns/1ns
`default_nettype none
module dtei_properties (
	// Clock and reset
	input wire logic        clock,
	input wire logic        sys_rst,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Pin, acknowledge and flags
	input wire logic        ext_irq_a_pin,
	input wire logic        ack_ext_a,
	input wire logic [3:0]  request_flags,
	input wire logic        irq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire       taken = hsel && htrans[1] && hready;
	wire       rd_bad = taken && !hwrite && (haddr[31:10] != 22'h0 || haddr[9:2] == 8'h8f);
	reg        dp_wr;
	reg  [7:0] dp_idx;
	reg        type_a;
	reg  [3:0] mask_sh;
	wire       ctrl_wr = dp_wr && dp_idx == 8'h88;
	// Shadow of type and mask bits, so flag checks know the mode without peeking inside
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			dp_wr <= 1'b0;
			dp_idx <= 8'h0;
			type_a <= 1'b0;
			mask_sh <= 4'h0;
		end else begin
			dp_wr <= taken && hwrite && haddr[31:10] == 22'h0;
			dp_idx <= haddr[9:2];
			if (ctrl_wr) type_a <= hwdata[0];
			if (dp_wr && dp_idx == 8'h91) mask_sh <= hwdata[3:0];
		end
	end
	AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
	AST_RD_UPPER: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
	AST_RD_HOLD: assert property (!(taken && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
	AST_UNMAPPED: assert property (rd_bad |=> hrdata == 32'h0) else $error("unmapped read not zero");
	AST_LEVEL_LOW: assert property ((!type_a && !ext_irq_a_pin)[*4] |-> request_flags[2])
		else $error("level request missing");
	AST_LEVEL_HIGH: assert property ((!type_a && ext_irq_a_pin)[*4] |-> !request_flags[2])
		else $error("level request stuck");
	AST_EDGE_STICKY: assert property (type_a && request_flags[2] && !ack_ext_a && !ctrl_wr |=> request_flags[2])
		else $error("edge request lost");
	AST_EDGE_ACK: assert property (type_a && ack_ext_a && !ctrl_wr && ext_irq_a_pin && $past(ext_irq_a_pin)
		&& $past(ext_irq_a_pin, 2) && $past(ext_irq_a_pin, 3) |=> !request_flags[2]) else $error("ack kept request");
	AST_EDGE_FALL: assert property (type_a && $past(type_a) && $rose(request_flags[2]) && !$past(ctrl_wr)
		|-> !$past(ext_irq_a_pin, 2) || !$past(ext_irq_a_pin, 3)) else $error("edge request without fall");
	AST_MASK: assert property (mask_sh == 4'h0 && $past(mask_sh) == 4'h0 |-> !irq) else $error("masked irq high");
endmodule
bind dtei_top dtei_properties prop_u (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .ext_irq_a_pin(ext_irq_a_pin), .ack_ext_a(ack_ext_a),
	.request_flags(request_flags), .irq(irq));
`default_nettype wire

// [tb/dtei_pin_model.sv]
// Board-side model of the count and interrupt pins
`timescale 1ns/1ns
`default_nettype none
module dtei_pin_model (
	// Clock
	input  wire logic       clock,
	// Count a, count b, interrupt a, interrupt b
	output var  logic [3:0] pins
);
	// Pins idle high, as pulled up on the board
	initial pins = 4'hf;
	// Each level lasts at least three clocks so the two-flop sampler sees it
	task automatic pulse(input int i, input int n);
		repeat (n) begin
			@(posedge clock);
			pins[i] <= 1'b0;
			repeat (3) @(posedge clock);
			pins[i] <= 1'b1;
			repeat (2) @(posedge clock);
		end
	endtask
	task automatic drive(input int i, input logic v);
		@(posedge clock);
		pins[i] <= v;
	endtask
endmodule
`default_nettype wire

// [tb/dual_timer_ext_irq_detect_bench.sv]
// Self-checking bench for the dual timer with external interrupt detectors
`timescale 1ns/1ns
`default_nettype none
module dual_timer_ext_irq_detect_bench;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [3:0]  ack = 4'h0;
	logic [31:0] seed = 32'h2e1b;
	logic [31:0] rd;
	logic [31:0] v;
	wire  [3:0]  pins;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire  [3:0]  request_flags;
	wire         irq;
	int          err_count = 0;
	int          checks = 0;
	int          cyc;
	// Clock at 100 MHz
	always #5 clock = ~clock;
	// The one slave drives the bus ready
	dtei_top dut_u (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .timer_a_count_pin(pins[0]), .timer_b_count_pin(pins[1]),
		.ext_irq_a_pin(pins[2]), .ext_irq_b_pin(pins[3]), .ack_timer_a(ack[0]), .ack_timer_b(ack[1]),
		.ack_ext_a(ack[2]), .ack_ext_b(ack[3]), .request_flags(request_flags), .irq(irq));
	dtei_pin_model pm_u (.clock(clock), .pins(pins));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Bounded wait for ready; a hang ends the run
	task automatic wait_rdy;
		int k;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1) begin
			err_count++;
			end_sim;
		end
	endtask
	// One single word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy;
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(rd, exp);
	endtask
	task automatic ack_pulse(input logic [3:0] m);
		ack <= m;
		tick(1);
		ack <= 4'h0;
		tick(1);
	endtask
	// Cycles until a request flag is seen, bounded
	task automatic wait_flag(input int b);
		cyc = 0;
		while (request_flags[b] !== 1'b1 && cyc < 3000) begin
			@(posedge clock);
			cyc++;
		end
		if (cyc >= 3000) begin
			err_count++;
			end_sim;
		end
	endtask
	initial begin
		tick(10);
		sys_rst <= 1'b0;
		tick(1);
		for (int i = 8'h88; i < 8'h8e; i++) rdc(i[7:0], 32'h0);
		rdc(8'h8f, 32'h0);
		for (int i = 8'h8a; i < 8'h8e; i++) begin
			seed = xs(seed);
			wr(i[7:0], seed[7:0]);
			tick(30);
			rdc(i[7:0], {24'h0, seed[7:0]});
		end
		$display("test registers done");
		// Sixteen-bit mode, fast tick, sixteen ticks to overflow, interrupt path
		wr(8'h8e, 8'h08);
		wr(8'h89, 8'h01);
		wr(8'h8c, 8'hff);
		wr(8'h8a, 8'hf0);
		wr(8'h91, 8'h01);
		wr(8'h88, 8'h10);
		wait_flag(0);
		chk(cyc >= 56 && cyc <= 68, 32'h1);
		chk(irq, 32'h1);
		wr(8'h88, 8'h20);
		rdc(8'h8c, 32'h0);
		ack_pulse(4'h1);
		chk(request_flags[0], 32'h0);
		chk(irq, 32'h1);
		wr(8'h90, 8'h01);
		tick(2);
		chk(irq, 32'h0);
		// Reload mode, slow tick, masked: period of four ticks of twelve clocks
		wr(8'h91, 8'h00);
		wr(8'h8e, 8'h00);
		wr(8'h89, 8'h02);
		wr(8'h8c, 8'hfc);
		wr(8'h8a, 8'hfc);
		wr(8'h88, 8'h10);
		wait_flag(0);
		wr(8'h88, 8'h10);
		tick(1);
		chk(request_flags[0], 32'h0);
		wait_flag(0);
		chk(cyc >= 38 && cyc <= 50, 32'h1);
		chk(irq, 32'h0);
		// Thirteen-bit mode: upper low bits held
		wr(8'h88, 8'h00);
		wr(8'h8e, 8'h08);
		wr(8'h89, 8'h00);
		wr(8'h8c, 8'hff);
		wr(8'h8a, 8'hfe);
		wr(8'h88, 8'h10);
		wait_flag(0);
		chk(cyc <= 12, 32'h1);
		wr(8'h88, 8'h00);
		bus(1'b0, 8'h8a, 8'h00);
		chk(rd[7:5], 32'h7);
		rdc(8'h8c, 32'h0);
		$display("test modes done");
		// Gate with the interrupt pin, level request alongside
		wr(8'h89, 8'h09);
		wr(8'h8a, 8'h00);
		wr(8'h8c, 8'h00);
		pm_u.drive(2, 1'b0);
		tick(3);
		wr(8'h88, 8'h10);
		tick(40);
		rdc(8'h8a, 32'h0);
		chk(request_flags[2], 32'h1);
		pm_u.drive(2, 1'b1);
		tick(40);
		bus(1'b0, 8'h8a, 8'h00);
		chk(rd >= 6 && rd <= 12, 32'h1);
		chk(request_flags[2], 32'h0);
		// Count pin pulses only
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h05);
		wr(8'h8a, 8'h00);
		wr(8'h88, 8'h10);
		pm_u.pulse(0, 5);
		tick(5);
		rdc(8'h8a, 32'h5);
		// Split mode: high byte on the second run bit, second timer by mode only
		wr(8'h88, 8'h00);
		wr(8'h8e, 8'h18);
		wr(8'h89, 8'h13);
		wr(8'h8a, 8'h40);
		wr(8'h8c, 8'hfe);
		wr(8'h8b, 8'h00);
		wr(8'h88, 8'h40);
		wait_flag(1);
		chk(cyc <= 16, 32'h1);
		ack_pulse(4'h2);
		chk(request_flags[1], 32'h0);
		rdc(8'h8a, 32'h40);
		wr(8'h88, 8'h00);
		bus(1'b0, 8'h8b, 8'h00);
		v = rd;
		tick(40);
		bus(1'b0, 8'h8b, 8'h00);
		chk(rd != v, 32'h1);
		wr(8'h89, 8'h33);
		tick(2);
		bus(1'b0, 8'h8b, 8'h00);
		v = rd;
		tick(40);
		rdc(8'h8b, v);
		// Second timer on its count pin in reload mode, with its own overflow flag
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h60);
		wr(8'h8d, 8'hfe);
		wr(8'h8b, 8'hfd);
		wr(8'h88, 8'h40);
		pm_u.pulse(1, 3);
		tick(2);
		chk(request_flags[1], 32'h1);
		rdc(8'h8b, 32'hfe);
		$display("test split done");
		// Edge requests: sticky, cleared by acknowledge and by software
		wr(8'h88, 8'h01);
		pm_u.pulse(2, 1);
		tick(4);
		chk(request_flags[2], 32'h1);
		tick(20);
		chk(request_flags[2], 32'h1);
		ack_pulse(4'h4);
		chk(request_flags[2], 32'h0);
		pm_u.pulse(2, 1);
		tick(4);
		wr(8'h88, 8'h01);
		tick(1);
		chk(request_flags[2], 32'h0);
		pm_u.drive(3, 1'b0);
		tick(4);
		chk(request_flags[3], 32'h1);
		pm_u.drive(3, 1'b1);
		// Edge request on the second pin, cleared by its own acknowledge
		wr(8'h88, 8'h04);
		pm_u.pulse(3, 1);
		tick(4);
		chk(request_flags[3], 32'h1);
		ack_pulse(4'h8);
		chk(request_flags[3], 32'h0);
		$display("test pins done");
		end_sim;
	end
endmodule
`default_nettype wire
